// [rtl/rpsi_pkg.sv]
`default_nettype none

package rpsi_pkg;

    // Profile numbering on the six remote select lines.
    localparam int          SEL_W       = 6;
    localparam logic [5:0]  PROF_NONE   = 6'h00;
    localparam logic [5:0]  PROF_FIRST  = 6'h01;
    localparam logic [5:0]  PROF_LAST   = 6'h3F;
    localparam int          PROF_SLOTS  = 64;

    // Stored-profile map after reset: only profile 1 holds valid contents.
    localparam logic [63:0] STORED_RST  = 64'h0000_0000_0000_0002;

    // Clock and debounce timing; the debounce is a least time, so it rounds up.
    localparam int          CLK_PERIOD_NS = 50;
    localparam int          DEBOUNCE_NS   = 1000000;
    localparam int          DEBOUNCE_CYC  = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W         = 24;
    localparam logic [23:0] CNT_ZERO      = 24'h000000;
    localparam logic [23:0] CNT_ONE       = 24'h000001;

    // Thermocouple type shared by both temperature channels.
    typedef enum logic [1:0] {
        RPSI_TC_E,
        RPSI_TC_J,
        RPSI_TC_K
    } rpsi_tc_t;

    // Control inputs as one group, so they are synchronised together.
    typedef struct packed {
        logic       estop_closed;  // High while the stop loop is intact.
        logic       alarm_reset;   // High while the reset line is applied.
        logic [5:0] sel;           // Remote select lines, line 0 in bit 0.
    } rpsi_in_t;

    localparam rpsi_in_t IN_RST = '{estop_closed: 1'b0, alarm_reset: 1'b0, sel: 6'h00};

    // The whole state of the block.
    typedef struct packed {
        rpsi_in_t    sync1;          // First synchroniser stage.
        rpsi_in_t    sync2;          // Second synchroniser stage.
        rpsi_in_t    sync3;          // One-cycle history for change detection.
        rpsi_in_t    stable;         // Debounced view of the inputs.
        logic [23:0] cnt;            // Cycles the new input value has held.
        logic [5:0]  panel;          // Profile chosen on the front panel.
        logic [5:0]  active;         // Profile in force.
        logic        remote_mode;    // Remote lines own the selection.
        logic        recall_miss;    // Remote code names an empty slot.
        logic [63:0] stored;         // One bit per profile slot with contents.
        logic        store_we;       // One-cycle save strobe.
        logic [5:0]  store_idx;      // Slot being saved.
        logic        head_power;     // Head actuation power enable.
        logic        alarm_pend;     // Pending alarm.
        logic        limit_pend;     // Pending out-of-limits condition.
        rpsi_tc_t    tc_type;        // Decoded thermocouple type.
    } rpsi_state_t;

endpackage

`default_nettype wire

// [rtl/rpsi_remote_select.sv]
`default_nettype none

module rpsi_remote_select
    import rpsi_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic [5:0] remote_profile_select_line,
    input  wire logic       alarm_reset_in,
    input  wire logic       estop_loop_closed,
    input  wire logic       panel_up_pulse,
    input  wire logic       panel_down_pulse,
    input  wire logic       panel_save_pulse,
    input  wire logic       alarm_event,
    input  wire logic       limit_event,
    input  wire logic       strap_1_2_bridged,
    input  wire logic       strap_2_3_bridged,
    output logic [5:0]      active_profile,
    output logic            remote_mode,
    output logic            recall_miss,
    output logic            store_we,
    output logic [5:0]      store_profile,
    output logic            head_power_en,
    output logic            alarm_pending,
    output logic            limit_pending,
    output rpsi_tc_t        main_tc_type,
    output rpsi_tc_t        aux_tc_type
);

    ////////////////////////////////////////////////////////////////////////////////
    // State and helpers.

    rpsi_state_t r_reg;   // Registered state.
    rpsi_state_t r_next;  // Next state.

    // Debounce limit, cut to the counter width once here.
    localparam logic [23:0] DEB_LAST = CNT_W'(DEBOUNCE_CYCLES - 1);

    // Step a panel profile up or down, wrapping inside 1..63 so zero never appears.
    function automatic logic [5:0] rpsi_step(input logic [5:0] p, input logic up);
        logic [5:0] n;
        n = p;
        if (up) begin
            n = (p == PROF_LAST) ? PROF_FIRST : p + PROF_FIRST;
        end else begin
            n = (p == PROF_FIRST) ? PROF_LAST : p - PROF_FIRST;
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    // Control-input decisions use the debounced view, except the stop loop cut-off; keys, events and straps are used as they arrive.
    always_comb begin
        r_next          = r_reg;
        r_next.store_we = 1'b0;

        // Two-stage synchroniser; sync1 feeds only sync2.
        r_next.sync1 = '{estop_closed: estop_loop_closed, alarm_reset: alarm_reset_in,
                         sel: remote_profile_select_line};
        r_next.sync2 = r_reg.sync1;
        r_next.sync3 = r_reg.sync2;

        // The count restarts on every change, so a glitch never reaches the stable view.
        if (r_reg.sync2 != r_reg.sync3 || r_reg.sync2 == r_reg.stable) begin
            r_next.cnt = CNT_ZERO;
        end else if (r_reg.cnt == DEB_LAST) begin
            r_next.stable = r_reg.sync2;
            r_next.cnt    = CNT_ZERO;
        end else begin
            r_next.cnt = r_reg.cnt + CNT_ONE;
        end

        // Any nonzero code hands selection to the remote lines.
        r_next.remote_mode = (r_reg.stable.sel != PROF_NONE);

        if (r_reg.stable.sel != PROF_NONE) begin
            // The code is read as a plain binary number; empty slots are not recalled.
            if (r_reg.stored[r_reg.stable.sel]) begin
                r_next.active      = r_reg.stable.sel;
                r_next.recall_miss = 1'b0;
            end else begin
                r_next.recall_miss = 1'b1;
            end
        end else begin
            // Local control: panel keys move the profile, saving is allowed here only.
            r_next.recall_miss = 1'b0;
            r_next.active      = r_reg.panel;
            if (panel_up_pulse) begin
                r_next.panel = rpsi_step(r_reg.panel, 1'b1);
            end else if (panel_down_pulse) begin
                r_next.panel = rpsi_step(r_reg.panel, 1'b0);
            end
            if (panel_save_pulse) begin
                r_next.store_we                = 1'b1;
                r_next.store_idx               = r_reg.panel;
                r_next.stored[r_reg.panel]     = 1'b1;
            end
        end

        // Power drops straight from the synchronised loop, without waiting for the
        // debounce; it returns only once the closed loop has been stable.
        if (!r_reg.sync2.estop_closed) begin
            r_next.head_power = 1'b0;
        end else begin
            r_next.head_power = r_reg.stable.estop_closed;
        end

        // Reset clears pending flags; a new event in the same cycle wins.
        if (r_reg.stable.alarm_reset) begin
            r_next.alarm_pend = 1'b0;
            r_next.limit_pend = 1'b0;
        end
        if (alarm_event) begin
            r_next.alarm_pend = 1'b1;
        end
        if (limit_event) begin
            r_next.limit_pend = 1'b1;
        end

        // Strap decode; if both straps are fitted, J is taken.
        if (strap_1_2_bridged) begin
            r_next.tc_type = RPSI_TC_J;
        end else if (strap_2_3_bridged) begin
            r_next.tc_type = RPSI_TC_K;
        end else begin
            r_next.tc_type = RPSI_TC_E;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.

    // Reset loads constants only; profile 1 is active until a choice is made.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            r_reg             <= '0;
            r_reg.sync1       <= IN_RST;
            r_reg.sync2       <= IN_RST;
            r_reg.sync3       <= IN_RST;
            r_reg.stable      <= IN_RST;
            r_reg.panel       <= PROF_FIRST;
            r_reg.active      <= PROF_FIRST;
            r_reg.store_idx   <= PROF_FIRST;
            r_reg.stored      <= STORED_RST;
            r_reg.tc_type     <= RPSI_TC_E;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, all taken from the state register.

    assign active_profile = r_reg.active;
    assign remote_mode    = r_reg.remote_mode;
    assign recall_miss    = r_reg.recall_miss;
    assign store_we       = r_reg.store_we;
    assign store_profile  = r_reg.store_idx;
    assign head_power_en  = r_reg.head_power;
    assign alarm_pending  = r_reg.alarm_pend;
    assign limit_pending  = r_reg.limit_pend;
    assign main_tc_type   = r_reg.tc_type;
    // The auxiliary channel reuses the main decode and has no fault path at all.
    assign aux_tc_type    = r_reg.tc_type;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    // A stored remote code is in force one cycle later.
    property p_remote_pick;
        @(posedge ref_clk) disable iff (!rstn)
        (r_reg.stable.sel != PROF_NONE && r_reg.stored[r_reg.stable.sel])
        |=> (active_profile == $past(r_reg.stable.sel) && remote_mode);
    endproperty
    a_remote_pick: assert property (p_remote_pick) else $error("remote code not applied");

    // With all lines idle the panel choice is in force.
    property p_local_pick;
        @(posedge ref_clk) disable iff (!rstn)
        (r_reg.stable.sel == PROF_NONE) |=> (active_profile == $past(r_reg.panel) && !remote_mode);
    endproperty
    a_local_pick: assert property (p_local_pick) else $error("panel choice not applied");

    // Keys do nothing while the remote lines own the selection.
    property p_keys_ignored;
        @(posedge ref_clk) disable iff (!rstn)
        (r_reg.stable.sel != PROF_NONE && (panel_up_pulse || panel_down_pulse)) |=> $stable(r_reg.panel);
    endproperty
    a_keys_ignored: assert property (p_keys_ignored) else $error("panel key acted in remote mode");

    // Profile zero is never in force nor on the panel.
    property p_no_zero;
        @(posedge ref_clk) disable iff (!rstn)
        (active_profile != PROF_NONE) && (r_reg.panel != PROF_NONE);
    endproperty
    a_no_zero: assert property (p_no_zero) else $error("profile zero selected");

    // A save happens only from local control, and marks the slot stored.
    property p_save_local;
        @(posedge ref_clk) disable iff (!rstn)
        store_we |-> ($past(r_reg.stable.sel) == PROF_NONE && r_reg.stored[store_profile]);
    endproperty
    a_save_local: assert property (p_save_local) else $error("save outside local control");

    // An empty slot named remotely leaves the active profile alone.
    property p_empty_slot;
        @(posedge ref_clk) disable iff (!rstn)
        (r_reg.stable.sel != PROF_NONE && !r_reg.stored[r_reg.stable.sel])
        |=> (recall_miss && $stable(active_profile));
    endproperty
    a_empty_slot: assert property (p_empty_slot) else $error("empty slot recalled");

    // Reset without a new event leaves both flags clear.
    property p_alarm_clear;
        @(posedge ref_clk) disable iff (!rstn)
        (r_reg.stable.alarm_reset && !alarm_event && !limit_event) |=> (!alarm_pending && !limit_pending);
    endproperty
    a_alarm_clear: assert property (p_alarm_clear) else $error("alarms not cleared");

    // An open loop held for three cycles has removed head power on the next.
    sequence s_loop_open;
        !estop_loop_closed [*3];
    endsequence
    property p_estop;
        @(posedge ref_clk) disable iff (!rstn)
        s_loop_open |=> !head_power_en;
    endproperty
    a_estop: assert property (p_estop) else $error("head power not removed");

    // Strap 2-3 alone gives type K on the main channel.
    property p_strap_k;
        @(posedge ref_clk) disable iff (!rstn)
        (strap_2_3_bridged && !strap_1_2_bridged) |=> (main_tc_type == RPSI_TC_K);
    endproperty
    a_strap_k: assert property (p_strap_k) else $error("strap decode wrong");

    // Both channels always share one type.
    property p_same_type;
        @(posedge ref_clk) disable iff (!rstn)
        aux_tc_type == main_tc_type;
    endproperty
    a_same_type: assert property (p_same_type) else $error("channel types differ");

    // The debounced view moves only after the full count.
    property p_debounce;
        @(posedge ref_clk) disable iff (!rstn)
        $changed(r_reg.stable) |-> ($past(r_reg.cnt) == DEB_LAST);
    endproperty
    a_debounce: assert property (p_debounce) else $error("input taken before debounce");

    // Head power comes back only after the closed loop has passed the debounce.
    property p_power_restore;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(head_power_en) |-> $past(r_reg.stable.estop_closed);
    endproperty
    a_power_restore: assert property (p_power_restore) else $error("head power restored early");

    // An alarm arriving in the cycle of a reset still leaves its flag set.
    property p_set_wins;
        @(posedge ref_clk) disable iff (!rstn)
        (r_reg.stable.alarm_reset && alarm_event) |=> alarm_pending;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("alarm lost to reset");

    // Strap 1-2 gives type J, and it wins when both straps are fitted.
    property p_strap_j;
        @(posedge ref_clk) disable iff (!rstn)
        strap_1_2_bridged |=> (main_tc_type == RPSI_TC_J);
    endproperty
    a_strap_j: assert property (p_strap_j) else $error("strap J decode wrong");

    // No strap fitted gives type E.
    property p_strap_e;
        @(posedge ref_clk) disable iff (!rstn)
        (!strap_1_2_bridged && !strap_2_3_bridged) |=> (main_tc_type == RPSI_TC_E);
    endproperty
    a_strap_e: assert property (p_strap_e) else $error("strap E decode wrong");

    // Handing selection back to the panel clears a failed recall.
    property p_local_no_miss;
        @(posedge ref_clk) disable iff (!rstn)
        (r_reg.stable.sel == PROF_NONE) |=> !recall_miss;
    endproperty
    a_local_no_miss: assert property (p_local_no_miss) else $error("recall miss kept in local mode");

endmodule

`default_nettype wire

// [tb/rpsi_plc_model.sv]
`default_nettype none

// Far-side controller that drives the automation control inputs.
module rpsi_plc_model (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic [5:0] code_req,
    input  wire logic       reset_req,
    input  wire logic       stop_req,
    output logic [5:0]      sel_pins,
    output logic            alarm_reset_pin,
    output logic            estop_closed_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // Pins change only just after an edge, and all six code lines change in the same cycle.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sel_pins         <= 6'h00;
            alarm_reset_pin  <= 1'b0;
            estop_closed_pin <= 1'b1;
        end else begin
            sel_pins         <= code_req;
            alarm_reset_pin  <= reset_req;
            estop_closed_pin <= !stop_req;
        end
    end
endmodule

`default_nettype wire

// [tb/rpsi_remote_select_tb.sv]
`default_nettype none

module rpsi_remote_select_tb;
    import rpsi_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic       ref_clk, rstn, up, down, save, alarm_ev, limit_ev, s12, s23;
    logic       reset_req, stop_req, alarm_pin, estop_pin, we_seen;
    logic [5:0] code_req, sel_pins, active_profile, store_profile;
    logic       remote_mode, recall_miss, store_we, head_power_en, alarm_pending, limit_pending;
    rpsi_tc_t   main_tc, aux_tc;
    int         fails, n_compared, cycles;

    ////////////////////////////////////////////////////////////////////////////////
    // A short debounce keeps the run brief; waits below allow for it plus the sync stages.
    rpsi_remote_select #(.DEBOUNCE_CYCLES(4)) i_dut (
        .ref_clk(ref_clk), .rstn(rstn), .remote_profile_select_line(sel_pins),
        .alarm_reset_in(alarm_pin), .estop_loop_closed(estop_pin),
        .panel_up_pulse(up), .panel_down_pulse(down), .panel_save_pulse(save),
        .alarm_event(alarm_ev), .limit_event(limit_ev),
        .strap_1_2_bridged(s12), .strap_2_3_bridged(s23),
        .active_profile(active_profile), .remote_mode(remote_mode), .recall_miss(recall_miss),
        .store_we(store_we), .store_profile(store_profile), .head_power_en(head_power_en),
        .alarm_pending(alarm_pending), .limit_pending(limit_pending),
        .main_tc_type(main_tc), .aux_tc_type(aux_tc));

    rpsi_plc_model i_plc (
        .ref_clk(ref_clk), .rstn(rstn), .code_req(code_req), .reset_req(reset_req),
        .stop_req(stop_req), .sel_pins(sel_pins), .alarm_reset_pin(alarm_pin),
        .estop_closed_pin(estop_pin));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 20 MHz, and a ceiling that cuts a hang short.
    always #25 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            $display("ERROR %0t run did not complete in time", $time);
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("Compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One comparison; case inequality so an unknown never matches.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // One-cycle key press; the save strobe is caught in the one cycle it stands.
    task automatic key(input logic [2:0] k);
        @(posedge ref_clk);
        {up, down, save} <= k;
        @(posedge ref_clk);
        {up, down, save} <= 3'h0;
        #1 we_seen = store_we;
        tick(3);
    endtask

    // New code from the controller, then time for sync, debounce and update.
    task automatic set_code(input logic [5:0] c);
        @(posedge ref_clk);
        code_req <= c;
        tick(14);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(active_profile, 8'h01);
        chk(remote_mode, 8'h00);
        chk(head_power_en, 8'h00);
        chk(main_tc, RPSI_TC_E);
    endtask

    // Wrap at both ends and the up-wins tie, all in local mode.
    task automatic t_panel();
        key(3'h2);
        chk(active_profile, 8'h3F);
        key(3'h4);
        chk(active_profile, 8'h01);
        key(3'h6);
        chk(active_profile, 8'h02);
        key(3'h2);
        key(3'h2);
        chk(active_profile, 8'h3F);
        key(3'h1);
        chk(we_seen, 8'h01);
        chk(store_profile, 8'h3F);
    endtask

    // Remote codes: stored, keys locked out, unstored, glitch, hand-back.
    task automatic t_remote();
        set_code(6'h3F);
        chk(active_profile, 8'h3F);
        chk(remote_mode, 8'h01);
        key(3'h4);
        chk(active_profile, 8'h3F);
        key(3'h1);
        chk(we_seen, 8'h00);
        set_code(6'h05);
        chk(recall_miss, 8'h01);
        chk(active_profile, 8'h3F);
        @(posedge ref_clk);
        code_req <= 6'h01;
        tick(2);
        set_code(6'h05);
        chk(active_profile, 8'h3F);
        set_code(6'h01);
        chk(active_profile, 8'h01);
        chk(recall_miss, 8'h00);
        set_code(6'h00);
        chk(remote_mode, 8'h00);
        chk(active_profile, 8'h3F);
    endtask

    task automatic t_alarm();
        @(posedge ref_clk);
        {alarm_ev, limit_ev} <= 2'h3;
        @(posedge ref_clk);
        {alarm_ev, limit_ev} <= 2'h0;
        tick(2);
        chk({alarm_pending, limit_pending}, 8'h03);
        reset_req <= 1'b1;
        tick(14);
        chk({alarm_pending, limit_pending}, 8'h00);
        // With the reset still applied, an event in the same cycle must win for one cycle.
        @(posedge ref_clk);
        alarm_ev <= 1'b1;
        @(posedge ref_clk);
        alarm_ev <= 1'b0;
        #1 chk(alarm_pending, 8'h01);
        @(posedge ref_clk);
        reset_req <= 1'b0;
    endtask

    // The stop cut skips the debounce; restore waits for it.
    task automatic t_estop();
        chk(head_power_en, 8'h01);
        stop_req <= 1'b1;
        tick(5);
        chk(head_power_en, 8'h00);
        stop_req <= 1'b0;
        tick(14);
        chk(head_power_en, 8'h01);
    endtask

    task automatic t_strap();
        rpsi_tc_t exp_tc [4] = '{RPSI_TC_E, RPSI_TC_J, RPSI_TC_K, RPSI_TC_J};
        for (int i = 0; i < 4; i++) begin
            {s23, s12} <= 2'(i);
            tick(3);
            chk(main_tc, exp_tc[i]);
            chk(aux_tc, exp_tc[i]);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        rstn = 1'b0;
        {up, down, save, alarm_ev, limit_ev, s12, s23} = 7'h00;
        {reset_req, stop_req, we_seen} = 3'h0;
        code_req = 6'h00;
        {fails, n_compared, cycles} = '0;
        tick(10);
        t_reset();
        rstn <= 1'b1;
        tick(14);
        t_panel();
        t_remote();
        t_alarm();
        t_estop();
        t_strap();
        tally_and_finish();
    end
endmodule

`default_nettype wire
